// >>> hdl/ppt_pkg.sv
package ppt_pkg;

   // Widths
   localparam int LT_W = 16;
   localparam int VOTE_W = 8;

   // Stage delays in local clock ticks
   localparam int NRST_TICKS = 2;
   localparam int DIAG_TICKS = 3;
   localparam int IDU_TICKS = 1;
   localparam int ACCEPT_TICKS = 4;
   localparam int REOPEN_TICKS = 1;
   localparam int MODE_MSG_TICKS = 1;
   localparam int SCHED_INV_TICKS = 3;
   localparam int HOST_CMD_MIN = 5;
   localparam int SA_MSG_TICKS = 2;
   localparam int HOST_TX_TICKS = 2;
   localparam int ACC_RDY_TICKS = 1;
   localparam int ACC_TX_TICKS = 1;
   localparam int CLOSE_DIAG_TICKS = 4;

   // Reset, saturation and threshold values
   localparam logic [1:0] RDY_CNT = 2'(NRST_TICKS - 1);
   localparam logic [2:0] SINCE_MAX = 3'h7;
   localparam logic [2:0] SINCE_MIN = 3'(HOST_CMD_MIN);

   typedef enum logic [1:0] {
      PPT_IDLE = 2'b00,
      PPT_SYNC = 2'b01,
      PPT_SCHED = 2'b10,
      PPT_HOST = 2'b11
   } ppt_mode_e;

   typedef struct packed {
      logic node_rst;
      logic lt_clr;
      logic tx_cmd;
      logic sync_start;
      logic su_start;
      logic rwin_close;
      logic win_next;
      logic last_host_read;
      logic slot;
      logic my_turn;
   } ppt_cmd_s;

   typedef struct packed {
      logic ready;
      logic tx_strobe;
      logic rwin_open;
      logic idu_res;
      logic accept;
      logic mode_msg;
      logic host_cmd;
      logic assess_msg;
      logic acc_ready;
      logic acc_strobe;
      logic close_done;
      logic early_cmd;
   } ppt_evt_s;

   typedef struct packed {
      logic [VOTE_W-1:0] vote;
      logic [VOTE_W-1:0] limit;
      logic [2:0] vld;
      logic overrun;
      logic int_inv;
      logic out_inv;
   } ppt_sp_s;

   typedef struct packed {
      ppt_mode_e mode;
      logic [1:0] rdy_cnt;
      logic [LT_W-1:0] lt;
      logic [3:0] diag_sr;
      logic [3:0] cdiag_sr;
      logic [3:0] acc_sr;
      logic [3:0] host_sr;
      logic tx_pend;
      logic close_pend;
      logic [2:0] since_idu;
      ppt_evt_s ev;
   } ppt_state_s;

endpackage : ppt_pkg

// >>> hdl/ppt_sched_proc.sv
`timescale 1ns/100ps
module ppt_sched_proc (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic clr_i,
   // Capture of the vote result
   input wire logic cap_i,
   input wire logic [ppt_pkg::VOTE_W-1:0] vote_cnt_i,
   input wire logic [ppt_pkg::VOTE_W-1:0] vote_limit_i,
   // Schedule assessment
   output logic overrun_o,
   output logic sched_inv_o
);
   import ppt_pkg::*;

   ppt_sp_s sp_ff;
   ppt_sp_s nxt_sp;

   // Limit travels with the vote so a later change cannot skew a result
   always_comb begin
      nxt_sp = sp_ff;
      nxt_sp.vld = {sp_ff.vld[1:0], cap_i};
      if (cap_i) begin
         nxt_sp.vote = vote_cnt_i;
         nxt_sp.limit = vote_limit_i;
      end
      if (sp_ff.vld[0]) begin
         nxt_sp.overrun = sp_ff.vote > sp_ff.limit;
      end
      if (sp_ff.vld[1]) begin
         nxt_sp.int_inv = sp_ff.overrun;
      end
      if (sp_ff.vld[2]) begin
         nxt_sp.out_inv = sp_ff.int_inv;
      end
      if (clr_i) begin
         nxt_sp = '0;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sp_ff <= '0;
      end else begin
         sp_ff <= nxt_sp;
      end
   end

   assign overrun_o = sp_ff.overrun;
   assign sched_inv_o = sp_ff.out_inv;

   sp_overrun_a: assert property (
      @(posedge mclk_i) disable iff (rst_i || clr_i)
      cap_i |-> ##2 (overrun_o ==
         ($past(vote_cnt_i, 2) > $past(vote_limit_i, 2))))
      else $error("overrun flag wrong two ticks after capture");

   sp_invalid_a: assert property (
      @(posedge mclk_i) disable iff (rst_i || clr_i)
      cap_i |-> ##4 (sched_inv_o ==
         ($past(vote_cnt_i, 4) > $past(vote_limit_i, 4))))
      else $error("schedule invalid not ready three ticks after result");

endmodule : ppt_sched_proc

// >>> hdl/ppt_timing.sv
`timescale 1ns/100ps
module ppt_timing (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Sequencer commands and host phase start time
   input wire ppt_pkg::ppt_cmd_s cmd_i,
   input wire logic [ppt_pkg::LT_W-1:0] host_phase_start_time_i,
   // Vote stage results
   input wire logic [ppt_pkg::VOTE_W-1:0] vote_cnt_i,
   input wire logic [ppt_pkg::VOTE_W-1:0] vote_limit_i,
   // Stage events, mode and local time out
   output ppt_pkg::ppt_evt_s evt_o,
   output ppt_pkg::ppt_mode_e mode_o,
   output logic [ppt_pkg::LT_W-1:0] local_time_count_o,
   // Schedule assessment
   output logic overrun_o,
   output logic sched_inv_o
);
   import ppt_pkg::*;

   ppt_state_s st_ff;
   ppt_state_s nxt_st;
   ppt_cmd_s cmd_g;
   logic host_go;
   logic tx_busy;
   logic sync_close;
   logic close_idu;

   function automatic logic [3:0] shl(input logic [3:0] v,
                                      input logic b);
      return {v[2:0], b};
   endfunction : shl

   // Commands other than node reset are ignored until the sub-units have recovered
   assign cmd_g = st_ff.ev.ready ? cmd_i : ppt_cmd_s'('0);

   // Diagnosis of the last window still in flight blocks a new send
   assign tx_busy = st_ff.ev.idu_res | st_ff.diag_sr[0];

   assign sync_close = cmd_g.rwin_close && st_ff.mode == PPT_SYNC;

   assign close_idu = st_ff.ev.idu_res & st_ff.close_pend;

   assign host_go = st_ff.mode == PPT_SCHED &&
      st_ff.lt == LT_W'(host_phase_start_time_i - 1'b1);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ev = '0;
      nxt_st.ev.ready = st_ff.ev.ready;
      nxt_st.ev.early_cmd = st_ff.ev.early_cmd;

      // Local time
      if (cmd_g.lt_clr) begin
         nxt_st.lt = '0;
      end else begin
         nxt_st.lt = st_ff.lt + 1'b1;
      end

      // Recovery countdown after node reset
      if (st_ff.rdy_cnt != 2'h0) begin
         nxt_st.rdy_cnt = st_ff.rdy_cnt - 2'h1;
         nxt_st.ev.ready = st_ff.rdy_cnt == 2'h1;
      end

      // Input diagnosis follows each window close
      nxt_st.ev.idu_res = cmd_g.rwin_close;
      if (cmd_g.rwin_close) begin
         nxt_st.since_idu = 3'h0;
      end else if (st_ff.since_idu != SINCE_MAX) begin
         nxt_st.since_idu = st_ff.since_idu + 3'h1;
      end

      // Node diagnosis, health monitor, then transmit
      nxt_st.diag_sr = shl(st_ff.diag_sr,
                           st_ff.ev.idu_res & ~st_ff.close_pend);

      // A finished send leaves the stage free at once
      if (cmd_g.tx_cmd || st_ff.tx_pend) begin
         if (tx_busy) begin
            nxt_st.tx_pend = 1'b1;
         end else begin
            nxt_st.tx_pend = 1'b0;
            nxt_st.ev.tx_strobe = 1'b1;
         end
      end

      // Receive windows
      if (st_ff.mode == PPT_SYNC) begin
         nxt_st.ev.rwin_open = st_ff.ev.accept;
      end else begin
         nxt_st.ev.rwin_open = cmd_g.rwin_close & cmd_g.win_next;
      end

      // Accept comes a fixed four ticks after the close
      nxt_st.acc_sr = shl(st_ff.acc_sr, sync_close);
      nxt_st.ev.accept = st_ff.acc_sr[ACCEPT_TICKS-2];

      // Schedule update start
      nxt_st.ev.mode_msg = cmd_g.su_start;

      // Host communication command
      nxt_st.ev.host_cmd = host_go;
      nxt_st.host_sr = shl(st_ff.host_sr, host_go);
      // The command lands a tick after host_go, so one tick less is allowed
      if (host_go && st_ff.since_idu < SINCE_MIN - 3'h1) begin
         nxt_st.ev.early_cmd = 1'b1;
      end
      nxt_st.ev.assess_msg = st_ff.host_sr[SA_MSG_TICKS-1];
      if (st_ff.host_sr[HOST_TX_TICKS-1]) begin
         nxt_st.ev.tx_strobe = 1'b1;
      end

      // Accusations in the slots of other nodes
      if (st_ff.mode == PPT_HOST) begin
         nxt_st.ev.acc_strobe = cmd_g.slot & ~cmd_g.my_turn;
         nxt_st.ev.acc_ready = cmd_g.last_host_read;
      end
      if (st_ff.ev.acc_ready) begin
         nxt_st.ev.acc_strobe = 1'b1;
         nxt_st.close_pend = 1'b1;
      end

      // Closing diagnosis reduces suspicions, so one tick longer
      nxt_st.cdiag_sr = shl(st_ff.cdiag_sr, close_idu);
      nxt_st.ev.close_done = st_ff.cdiag_sr[CLOSE_DIAG_TICKS-2];

      // Mode sequencing
      case (st_ff.mode)
         PPT_IDLE: begin
            if (cmd_g.sync_start) begin
               nxt_st.mode = PPT_SYNC;
            end else if (cmd_g.su_start) begin
               nxt_st.mode = PPT_SCHED;
            end
         end
         PPT_SYNC: begin
            if (cmd_g.su_start) begin
               nxt_st.mode = PPT_SCHED;
            end
         end
         PPT_SCHED: begin
            if (host_go) begin
               nxt_st.mode = PPT_HOST;
            end
         end
         PPT_HOST: begin
            if (st_ff.ev.close_done) begin
               nxt_st.mode = PPT_IDLE;
               nxt_st.close_pend = 1'b0;
            end
         end
         default: begin
            nxt_st.mode = PPT_IDLE;
         end
      endcase

      // Node reset acts on the clock, like every other stage
      if (cmd_i.node_rst) begin
         nxt_st = '0;
         nxt_st.rdy_cnt = RDY_CNT;
      end
   end

   // Every stage register moves on the same edge
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.rdy_cnt <= RDY_CNT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Capture edge is the one that raises the diagnosis result
   ppt_sched_proc u_sched (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .clr_i(cmd_i.node_rst),
      .cap_i(nxt_st.ev.idu_res),
      .vote_cnt_i(vote_cnt_i),
      .vote_limit_i(vote_limit_i),
      .overrun_o(overrun_o),
      .sched_inv_o(sched_inv_o)
   );

   assign evt_o = st_ff.ev;
   assign mode_o = st_ff.mode;
   assign local_time_count_o = st_ff.lt;

   default clocking dflt_cb @(posedge mclk_i);
   endclocking

   default disable iff (rst_i || cmd_i.node_rst);

   sequence rst_seq;
      cmd_i.node_rst ##1 !cmd_i.node_rst;
   endsequence

   sequence recover_seq;
      !evt_o.ready ##1 evt_o.ready;
   endsequence

   sequence close_ready_seq;
      evt_o.acc_ready ##1 evt_o.acc_strobe;
   endsequence

   node_reset_ready_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rst_seq |-> recover_seq)
      else $error("sub-units not ready two ticks after node reset");

   tx_no_delay_a: assert property (
      (cmd_g.tx_cmd && !tx_busy && !st_ff.tx_pend) |=> evt_o.tx_strobe)
      else $error("transmit stage added a start delay");

   rwin_reopen_a: assert property (
      (cmd_g.rwin_close && cmd_g.win_next && st_ff.mode != PPT_SYNC)
      |=> evt_o.rwin_open)
      else $error("window did not reopen the tick after closing");

   diag_spacing_a: assert property (
      (evt_o.idu_res && cmd_g.tx_cmd && mode_o != PPT_HOST &&
       !host_go && !st_ff.close_pend)
      |=> !evt_o.tx_strobe [*2] ##1 evt_o.tx_strobe)
      else $error("send not spaced three ticks after diagnosis");

   idu_delay_a: assert property (
      evt_o.idu_res == $past(cmd_g.rwin_close))
      else $error("input diagnosis result not one tick after close");

   accept_delay_a: assert property (
      sync_close |-> ##4 evt_o.accept)
      else $error("accept not four ticks after window close");

   accept_cause_a: assert property (
      evt_o.accept |-> $past(sync_close, 4))
      else $error("accept without a window close four ticks before");

   accept_reopen_a: assert property (
      (evt_o.accept && mode_o == PPT_SYNC) |=> evt_o.rwin_open)
      else $error("window not reopened one tick after accept");

   mode_msg_a: assert property (
      cmd_g.su_start |=> evt_o.mode_msg)
      else $error("mode message not one tick after update start");

   early_host_a: assert property (
      (host_go && st_ff.since_idu < SINCE_MIN - 3'h1) |=> evt_o.early_cmd)
      else $error("early host command not flagged");

   host_start_a: assert property (
      (mode_o == PPT_SCHED &&
       local_time_count_o == LT_W'(host_phase_start_time_i - 1'b1))
      |=> evt_o.host_cmd && mode_o == PPT_HOST)
      else $error("host command missed at start time minus one");

   assess_msg_a: assert property (
      evt_o.host_cmd |-> ##2 evt_o.assess_msg)
      else $error("assessment message not two ticks after command");

   host_first_tx_a: assert property (
      evt_o.host_cmd |-> ##2 evt_o.tx_strobe)
      else $error("first host strobe lacks its extra tick");

   acc_slot_a: assert property (
      (mode_o == PPT_HOST && cmd_g.slot && !cmd_g.my_turn)
      |=> evt_o.acc_strobe)
      else $error("accusations not sent in a foreign slot");

   acc_close_a: assert property (
      (mode_o == PPT_HOST && cmd_g.last_host_read) |=> close_ready_seq)
      else $error("closing accusations not ready then strobed");

   close_diag_a: assert property (
      close_idu |-> ##4 evt_o.close_done)
      else $error("closing diagnosis not done four ticks after result");

endmodule : ppt_timing

// >>> verification/ppt_far_end.sv
`timescale 1ns/100ps
module ppt_far_end (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Vote stage stimulus selection
   input wire logic over_i,
   // Host side observation
   input wire ppt_pkg::ppt_evt_s evt_i,
   // Vote stage results and host message count
   output logic [ppt_pkg::VOTE_W-1:0] vote_cnt_o,
   output logic [ppt_pkg::VOTE_W-1:0] vote_limit_o,
   output logic [7:0] host_msgs_o
);
   import ppt_pkg::*;

   // Count equal to the limit is the boundary that must not read as overrun
   assign vote_limit_o = 8'h20;
   assign vote_cnt_o = over_i ? 8'h21 : 8'h20;

   // Host processor takes one message per cycle with a mode or assessment strobe high
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         host_msgs_o <= 8'h00;
      end else if (evt_i.mode_msg || evt_i.assess_msg) begin
         host_msgs_o <= host_msgs_o + 8'h01;
      end
   end
endmodule : ppt_far_end

// >>> verification/protocol_phase_timing_test.sv
`timescale 1ns/100ps
module protocol_phase_timing_test;
   import ppt_pkg::*;

   localparam logic [9:0] C_NRST = 10'h200;
   localparam logic [9:0] C_LTCLR = 10'h100;
   localparam logic [9:0] C_TX = 10'h080;
   localparam logic [9:0] C_SYNC = 10'h040;
   localparam logic [9:0] C_SU = 10'h020;
   localparam logic [9:0] C_CLOSE = 10'h010;
   localparam logic [9:0] C_NEXT = 10'h008;
   localparam logic [9:0] C_LAST = 10'h004;
   localparam logic [9:0] C_SLOT = 10'h002;
   localparam logic [9:0] C_TURN = 10'h001;
   // Bit positions in a trace entry {evt, mode, overrun, invalid}
   localparam int TXS = 14;
   localparam int OPN = 13;
   localparam int INPUT_DIAGNOSIS_STAGE = 12;
   localparam int ACC = 11;
   localparam int MM = 10;
   localparam int HC = 9;
   localparam int ASM = 8;
   localparam int ACR = 7;
   localparam int ACS = 6;
   localparam int CD = 5;
   localparam int ERL = 4;
   localparam int OVR = 1;
   localparam int INV = 0;

   logic mclk_i;
   logic rst_i;
   ppt_cmd_s cmd_i;
   logic [LT_W-1:0] start_time;
   logic over;
   logic [VOTE_W-1:0] vote_cnt;
   logic [VOTE_W-1:0] vote_limit;
   ppt_evt_s evt;
   ppt_mode_e mode;
   logic [LT_W-1:0] lt;
   logic ovr;
   logic inv;
   logic [7:0] host_msgs;
   logic [15:0] tr [0:15];
   int failures;
   int n_checks;

   ppt_timing ppt_timing_inst (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .cmd_i(cmd_i),
      .host_phase_start_time_i(start_time),
      .vote_cnt_i(vote_cnt),
      .vote_limit_i(vote_limit),
      .evt_o(evt),
      .mode_o(mode),
      .local_time_count_o(lt),
      .overrun_o(ovr),
      .sched_inv_o(inv)
   );

   ppt_far_end ppt_far_end_inst (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .over_i(over),
      .evt_i(evt),
      .vote_cnt_o(vote_cnt),
      .vote_limit_o(vote_limit),
      .host_msgs_o(host_msgs)
   );

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Command held for one cycle; tr[k] is the state k cycles later
   // A one-cycle run leaves its command for the next run to replace
   task automatic run(input logic [9:0] c, input int n);
      cmd_i = c;
      for (int i = 0; i < n; i++) begin
         tr[i] = {evt, mode, ovr, inv};
         @(negedge mclk_i);
         if (i == 0 && n > 1) begin
            cmd_i = '0;
         end
      end
   endtask : run

   // Pulse seen only at cycle hit, silent at every other traced cycle from 1 to n-1
   task automatic ex(input int idx, input int hit, input int n);
      for (int i = 1; i < n; i++) begin
         chk(16'(tr[i][idx]), 16'(i == hit));
      end
   endtask : ex

   task automatic lv(input int k, input int idx, input logic v);
      chk(16'(tr[k][idx]), 16'(v));
   endtask : lv

   task automatic md(input int k, input logic [1:0] m);
      chk(16'(tr[k][3:2]), 16'(m));
   endtask : md

   initial begin
      repeat (2000) @(posedge mclk_i);
      failures++;
      $display("watchdog expired");
      report_and_stop();
   end

   initial begin
      failures = 0;
      n_checks = 0;
      rst_i = 1'b1;
      cmd_i = '0;
      over = 1'b0;
      start_time = 16'h0005;
      repeat (16) @(negedge mclk_i);
      chk(16'(evt.ready), 16'h0000);
      rst_i = 1'b0;
      @(negedge mclk_i);
      chk(16'(evt.ready), 16'h0001);
      cmd_i = C_NRST;
      @(negedge mclk_i);
      // Offered while not ready, so it must leave no trace
      cmd_i = C_CLOSE;
      chk(16'(evt.ready), 16'h0000);
      @(negedge mclk_i);
      cmd_i = '0;
      chk(16'(evt.ready), 16'h0001);
      @(negedge mclk_i);
      chk(16'(evt.idu_res), 16'h0000);
      $display("test node_reset done");

      run(C_CLOSE | C_NEXT, 3);
      ex(OPN, 1, 3);
      ex(INPUT_DIAGNOSIS_STAGE, 1, 3);
      run(C_TX, 3);
      ex(TXS, 1, 3);
      run(C_CLOSE, 2);
      run(C_TX, 5);
      ex(TXS, 2, 5);
      // Send requested in the very cycle of the diagnosis result
      run(C_CLOSE, 1);
      run(C_TX, 5);
      ex(TXS, 3, 5);
      $display("test idle_timing done");

      run(C_SYNC, 2);
      md(1, PPT_SYNC);
      run(C_CLOSE | C_NEXT, 7);
      ex(INPUT_DIAGNOSIS_STAGE, 1, 7);
      ex(ACC, 4, 7);
      ex(OPN, 5, 7);
      $display("test sync_window done");

      run(C_SU, 2);
      ex(MM, 1, 2);
      md(1, PPT_SCHED);
      over = 1'b1;
      run(C_CLOSE | C_LTCLR, 9);
      lv(1, OVR, 1'b0);
      lv(2, OVR, 1'b1);
      lv(3, INV, 1'b0);
      lv(4, INV, 1'b1);
      ex(HC, 6, 9);
      lv(6, ERL, 1'b0);
      md(5, PPT_SCHED);
      md(6, PPT_HOST);
      ex(ASM, 8, 9);
      ex(TXS, 8, 9);
      $display("test host_start done");

      run(C_SLOT, 3);
      ex(ACS, 1, 3);
      run(C_SLOT | C_TURN, 3);
      ex(ACS, 0, 3);
      run(C_LAST, 4);
      ex(ACR, 1, 4);
      ex(ACS, 2, 4);
      over = 1'b0;
      run(C_CLOSE, 8);
      ex(INPUT_DIAGNOSIS_STAGE, 1, 8);
      ex(CD, 5, 8);
      md(5, PPT_HOST);
      md(6, PPT_IDLE);
      lv(1, OVR, 1'b1);
      lv(2, OVR, 1'b0);
      lv(3, INV, 1'b1);
      lv(4, INV, 1'b0);
      $display("test host_close done");

      over = 1'b1;
      start_time = 16'h0004;
      run(C_SU, 2);
      run(C_CLOSE | C_LTCLR, 8);
      ex(HC, 5, 8);
      lv(4, ERL, 1'b0);
      lv(5, ERL, 1'b1);
      @(negedge mclk_i);
      chk(16'(host_msgs), 16'h0004);
      chk(lt, 16'h0008);
      $display("test early_host done");
      report_and_stop();
   end
endmodule : protocol_phase_timing_test
